// *** core/comparator_pair_pkg.sv ***
// Package: register map, field positions and encodings for the comparator pair control block
package comparator_pair_pkg;
   localparam logic [3:0] ADDR_CTRL0     = 4'h0;
   localparam logic [3:0] ADDR_CTRL1     = 4'h1;
   localparam logic [3:0] ADDR_INSEL0    = 4'h2;
   localparam logic [3:0] ADDR_INSEL1    = 4'h3;
   localparam logic [3:0] ADDR_PINOUT    = 4'h4;
   localparam logic [3:0] ADDR_DIVIDER   = 4'h5;
   localparam logic [3:0] ADDR_WINDOW    = 4'h6;
   localparam logic [3:0] ADDR_STATUS    = 4'h7;
   localparam logic [3:0] ADDR_SOURCE    = 4'h8;
   localparam logic [3:0] ADDR_TRIM      = 4'h9;
   localparam logic [7:0] RESET_VALUE    = 8'h00;
   localparam int         POS_WEN        = 4;
   localparam int         POS_SRC_EN     = 7;
   localparam int         POS_WFLAG      = 2;
   localparam int         POS_FLAG1      = 1;
   localparam int         POS_FLAG0      = 0;
   localparam logic [2:0] NEG_RESERVED   = 3'h5;
   localparam logic [2:0] NEG_REFERENCE  = 3'h6;
   localparam logic [2:0] NEG_DIVIDER    = 3'h7;
   localparam logic [2:0] POS_RESERVED   = 3'h7;
   localparam logic [1:0] WIN_ABOVE      = 2'h0;
   localparam logic [1:0] WIN_INSIDE     = 2'h1;
   localparam logic [1:0] WIN_BELOW      = 2'h2;
   localparam logic [1:0] WIN_OUTSIDE    = 2'h3;
   localparam logic [1:0] EDGE_TOGGLE    = 2'h0;
   localparam logic [1:0] EDGE_FALLING   = 2'h2;
   localparam logic [1:0] EDGE_RISING    = 2'h3;
endpackage : comparator_pair_pkg

// *** core/comparator_pair_control.sv ***
// Control, routing and status logic for a pair of analog comparators
// Notes on behaviour
// R1: Positive select 000..110 routes pin 0..6; 111 reserved, selects nothing.
// R2: Negative select: pins 0,1,3,5,7, reserved, reference, divider level.
// R3: Second comparator pin-output bit drives its output onto pin 6.
// R4: First comparator pin-output bit drives its output onto pin 7.
// R5: Six-bit divider factor gives supply times (factor plus one) over 64.
// R6: Window enable bit 4 puts both comparators into window operation.
// R7: Window trigger condition: above, inside, below, outside.
// R8: Window priority field enables window request; zero disables.
// R9: Window position field reports above, inside, below, outside while enabled; code reports only above, inside, below.
// R10: Status bits 5 and 4 show live second and first comparator levels.
// R11: Window flag at status bit 2 sets on the chosen condition.
// R12: Window flag clears on vector service or one written; zero ignored.
// R13: Second flag at bit 1 sets per edge mode; clears on service or one.
// R14: First flag at bit 0 sets per edge mode; clears on service or one.
// R15: Source control bit 7 switches the constant current source on.
// R16: Source control bit 1 steers current to second comparator negative pin.
// R17: Source control bit 0 steers current to first comparator negative pin.
// R18: Software loads factory trim into four-bit trim field; device holds it.
// R19: Software writes zero to reserved bits; device ignores them.
// R20: Edge mode: 00 toggle, 01 reserved, 10 falling, 11 rising.
// R21: Comparator output is one when positive input exceeds negative input.
// R22: Events follow the edge condition whether or not interrupts are enabled.
// R23: Window position derived from both outputs: first upper, second lower bound.
// R24: Window flag sets only on entry into the selected condition.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module comparator_pair_control
   import comparator_pair_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   input  wire logic       first_cmp_raw,
   input  wire logic       second_cmp_raw,
   input  wire logic       first_vector_ack,
   input  wire logic       second_vector_ack,
   input  wire logic       window_vector_ack,
   output logic            first_enable,
   output logic            second_enable,
   output logic      [1:0] first_hysteresis,
   output logic      [1:0] second_hysteresis,
   output logic      [7:0] first_pos_route,
   output logic      [7:0] second_pos_route,
   output logic      [7:0] first_neg_pin_route,
   output logic      [7:0] second_neg_pin_route,
   output logic            first_neg_reference,
   output logic            second_neg_reference,
   output logic            first_neg_divider,
   output logic            second_neg_divider,
   output logic      [5:0] divider_factor,
   output logic      [7:0] pin_out_value,
   output logic      [7:0] pin_out_enable_b,
   output logic            source_enable,
   output logic      [7:0] source_pin_route,
   output logic      [3:0] source_trim_value,
   output logic            first_irq,
   output logic            second_irq,
   output logic            window_irq,
   output logic      [1:0] first_irq_priority,
   output logic      [1:0] second_irq_priority,
   output logic      [1:0] window_irq_priority,
   output logic            first_event,
   output logic            second_event,
   output logic            window_event
);

   logic [7:0] ctrl0_reg;
   logic [7:0] ctrl1_reg;
   logic [7:0] insel0_reg;
   logic [7:0] insel1_reg;
   logic [7:0] pinout_reg;
   logic [7:0] divider_reg;
   logic [7:0] window_reg;
   logic [7:0] source_reg;
   logic [7:0] trim_reg;
   logic [2:0] flags_reg;
   logic [2:0] flags_next;
   logic [2:0] sync0_reg;
   logic [2:0] sync1_reg;
   logic       first_level_reg;
   logic       second_level_reg;
   logic [1:0] position_prev_reg;
   logic [7:0] rdata_next;
   logic       first_level_next;
   logic       second_level_next;

   // Three-stage synchronisers; a change counts once stages two and three agree
   // Stage one feeds only stage two, so no metastable value spreads
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sync0_reg <= 3'h0;
      end else begin
         sync0_reg <= {sync0_reg[1:0], first_cmp_raw};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sync1_reg <= 3'h0;
      end else begin
         sync1_reg <= {sync1_reg[1:0], second_cmp_raw};
      end
   end

   // Glitch filter holds the last agreed level
   assign first_level_next  = (sync0_reg[1] == sync0_reg[2]) ? sync0_reg[2] : first_level_reg;  // R21
   assign second_level_next = (sync1_reg[1] == sync1_reg[2]) ? sync1_reg[2] : second_level_reg; // R21

   // Field views
   wire [1:0] first_edge_mode  = ctrl0_reg[7:6];
   wire [1:0] second_edge_mode = ctrl1_reg[7:6];
   wire       window_on        = window_reg[POS_WEN];                        // R6
   wire [1:0] window_trigger   = window_reg[3:2];
   wire       write_hit        = reg_write;

   // Edge detection on the filtered levels
   wire first_rise   = first_level_next & ~first_level_reg;
   wire first_fall   = ~first_level_next & first_level_reg;
   wire second_rise  = second_level_next & ~second_level_reg;
   wire second_fall  = ~second_level_next & second_level_reg;

   function automatic logic edge_hit(input logic [1:0] mode, input logic rise, input logic fall);
      edge_hit = 1'b0;
      unique case (mode)
         EDGE_TOGGLE:  edge_hit = rise | fall;
         EDGE_FALLING: edge_hit = fall;
         EDGE_RISING:  edge_hit = rise;
         default:      edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   wire first_hit  = edge_hit(first_edge_mode, first_rise, first_fall);     // R20
   wire second_hit = edge_hit(second_edge_mode, second_rise, second_fall);  // R20

   // First comparator sets the upper bound, second the lower bound
   wire [1:0] position_now = first_level_next  ? WIN_ABOVE :
                             second_level_next ? WIN_INSIDE : WIN_BELOW;    // R23

   function automatic logic in_condition(input logic [1:0] cond, input logic [1:0] pos);
      in_condition = (cond == WIN_OUTSIDE) ? (pos != WIN_INSIDE) : (pos == cond);
   endfunction : in_condition

   // Entry only: held conditions do not re-fire
   wire window_hit = window_on & in_condition(window_trigger, position_now) &
                     ~in_condition(window_trigger, position_prev_reg);      // R7 R11 R24

   // Write-one-to-clear; a set in the same cycle wins over any clear
   wire       status_write = write_hit && reg_addr == ADDR_STATUS;
   wire [2:0] clear_mask   = (status_write ? reg_wdata[2:0] : 3'h0) |
                             {window_vector_ack, second_vector_ack, first_vector_ack}; // R12 R13 R14
   wire [2:0] set_mask     = {window_hit, second_hit, first_hit};                      // R11 R13 R14
   assign flags_next = (flags_reg & ~clear_mask) | set_mask;

   // Read-back; reserved bits read as zero
   wire [1:0] position_shown = window_on ? position_prev_reg : WIN_ABOVE;   // R9
   wire [7:0] status_view = {position_shown, second_level_reg, first_level_reg, 1'b0, flags_reg}; // R10
   always_comb begin
      unique case (reg_addr)
         ADDR_CTRL0:   rdata_next = ctrl0_reg;
         ADDR_CTRL1:   rdata_next = ctrl1_reg;
         ADDR_INSEL0:  rdata_next = insel0_reg;
         ADDR_INSEL1:  rdata_next = insel1_reg;
         ADDR_PINOUT:  rdata_next = pinout_reg;
         ADDR_DIVIDER: rdata_next = divider_reg;
         ADDR_WINDOW:  rdata_next = window_reg;
         ADDR_STATUS:  rdata_next = status_view;
         ADDR_SOURCE:  rdata_next = source_reg;
         ADDR_TRIM:    rdata_next = trim_reg;
         default:      rdata_next = 8'h00;
      endcase
   end

   // Writable registers; reserved bits are masked so they never store
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ctrl0_reg   <= RESET_VALUE;
         ctrl1_reg   <= RESET_VALUE;
         insel0_reg  <= RESET_VALUE;
         insel1_reg  <= RESET_VALUE;
         pinout_reg  <= RESET_VALUE;
         divider_reg <= RESET_VALUE;
         window_reg  <= RESET_VALUE;
         source_reg  <= RESET_VALUE;
         trim_reg    <= RESET_VALUE;
      end else if (write_hit) begin
         if (reg_addr == ADDR_CTRL0)   ctrl0_reg   <= reg_wdata & 8'hF7;  // R19
         if (reg_addr == ADDR_CTRL1)   ctrl1_reg   <= reg_wdata & 8'hF7;  // R19
         if (reg_addr == ADDR_INSEL0)  insel0_reg  <= reg_wdata & 8'h3F;  // R19
         if (reg_addr == ADDR_INSEL1)  insel1_reg  <= reg_wdata & 8'h3F;  // R19
         if (reg_addr == ADDR_PINOUT)  pinout_reg  <= reg_wdata & 8'h03;  // R19
         if (reg_addr == ADDR_DIVIDER) divider_reg <= reg_wdata & 8'h3F;  // R5
         if (reg_addr == ADDR_WINDOW)  window_reg  <= reg_wdata & 8'h1F;  // R6
         if (reg_addr == ADDR_SOURCE)  source_reg  <= reg_wdata & 8'h83;  // R15
         if (reg_addr == ADDR_TRIM)    trim_reg    <= reg_wdata & 8'h0F;  // R18
      end
   end

   // Pin decode of select fields
   function automatic logic [7:0] pos_decode(input logic [2:0] sel);
      pos_decode = (sel == POS_RESERVED) ? 8'h00 : 8'(8'h01 << sel);
   endfunction : pos_decode

   function automatic logic [7:0] neg_decode(input logic [2:0] sel);
      neg_decode = 8'h00;
      unique case (sel)
         3'h0:    neg_decode = 8'h01;
         3'h1:    neg_decode = 8'h02;
         3'h2:    neg_decode = 8'h08;
         3'h3:    neg_decode = 8'h20;
         3'h4:    neg_decode = 8'h80;
         default: neg_decode = 8'h00;
      endcase
   endfunction : neg_decode

   wire [7:0] pos0_dec = pos_decode(insel0_reg[5:3]);  // R1
   wire [7:0] pos1_dec = pos_decode(insel1_reg[5:3]);  // R1
   wire [7:0] neg0_dec = neg_decode(insel0_reg[2:0]);  // R2
   wire [7:0] neg1_dec = neg_decode(insel1_reg[2:0]);  // R2
   wire [7:0] pin_val  = {first_level_reg, second_level_reg, 6'h00};
   wire [7:0] pin_oe_b = ~{pinout_reg[0], pinout_reg[1], 6'h00};                 // R3 R4
   wire [7:0] src_route = (source_reg[1] ? neg1_dec : 8'h00) |
                          (source_reg[0] ? neg0_dec : 8'h00);                     // R16 R17
   wire       w_irq_level = flags_reg[POS_WFLAG] && window_reg[1:0] != 2'h0;     // R8

   // Filtered levels, window history and flags
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         first_level_reg      <= 1'b0;
         second_level_reg     <= 1'b0;
         position_prev_reg    <= WIN_ABOVE;
         flags_reg            <= 3'h0;
      end else begin
         first_level_reg      <= first_level_next;
         second_level_reg     <= second_level_next;
         position_prev_reg    <= position_now;
         flags_reg            <= flags_next;
      end
   end

   // Read data stands one cycle only; idle cycles show zero
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         reg_rdata            <= 8'h00;
      end else begin
         reg_rdata            <= reg_read ? rdata_next : 8'h00;
      end
   end

   // Per-comparator control passed straight through
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         first_enable         <= 1'b0;
         second_enable        <= 1'b0;
         first_hysteresis     <= 2'h0;
         second_hysteresis    <= 2'h0;
      end else begin
         first_enable         <= ctrl0_reg[0];
         second_enable        <= ctrl1_reg[0];
         first_hysteresis     <= ctrl0_reg[2:1];
         second_hysteresis    <= ctrl1_reg[2:1];
      end
   end

   // Routing is registered so switch controls never glitch
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         first_pos_route      <= 8'h00;
         second_pos_route     <= 8'h00;
         first_neg_pin_route  <= 8'h00;
         second_neg_pin_route <= 8'h00;
         first_neg_reference  <= 1'b0;
         second_neg_reference <= 1'b0;
         first_neg_divider    <= 1'b0;
         second_neg_divider   <= 1'b0;
      end else begin
         first_pos_route      <= pos0_dec;
         second_pos_route     <= pos1_dec;
         first_neg_pin_route  <= neg0_dec;
         second_neg_pin_route <= neg1_dec;
         first_neg_reference  <= insel0_reg[2:0] == NEG_REFERENCE;     // R2
         second_neg_reference <= insel1_reg[2:0] == NEG_REFERENCE;     // R2
         first_neg_divider    <= insel0_reg[2:0] == NEG_DIVIDER;       // R2
         second_neg_divider   <= insel1_reg[2:0] == NEG_DIVIDER;       // R2
      end
   end

   // Divider, pin drive and current source
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         divider_factor       <= 6'h00;
         pin_out_value        <= 8'h00;
         pin_out_enable_b     <= 8'hFF;
         source_enable        <= 1'b0;
         source_pin_route     <= 8'h00;
         source_trim_value    <= 4'h0;
      end else begin
         divider_factor       <= divider_reg[5:0];                     // R5
         pin_out_value        <= pin_val;                              // R3 R4
         pin_out_enable_b     <= pin_oe_b;
         source_enable        <= source_reg[POS_SRC_EN];               // R15
         source_pin_route     <= source_reg[POS_SRC_EN] ? src_route : 8'h00;
         source_trim_value    <= trim_reg[3:0];                        // R18
      end
   end

   // Requests follow the flags one cycle late
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         first_irq            <= 1'b0;
         second_irq           <= 1'b0;
         window_irq           <= 1'b0;
         first_irq_priority   <= 2'h0;
         second_irq_priority  <= 2'h0;
         window_irq_priority  <= 2'h0;
      end else begin
         first_irq            <= flags_reg[POS_FLAG0] && ctrl0_reg[5:4] != 2'h0;
         second_irq           <= flags_reg[POS_FLAG1] && ctrl1_reg[5:4] != 2'h0;
         window_irq           <= w_irq_level;                          // R8
         first_irq_priority   <= ctrl0_reg[5:4];
         second_irq_priority  <= ctrl1_reg[5:4];
         window_irq_priority  <= window_reg[1:0];
      end
   end

   // Events fire whether or not a request is enabled
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         first_event          <= 1'b0;
         second_event         <= 1'b0;
         window_event         <= 1'b0;
      end else begin
         first_event          <= first_hit;                            // R22
         second_event         <= second_hit;                           // R22
         window_event         <= window_hit;                           // R22
      end
   end

endmodule : comparator_pair_control

// *** verif/comparator_pair_analog.sv ***
// Partner model: the two analog comparator cores, inputs given in millivolts
`timescale 1ns/10ps
module comparator_pair_analog (
   input  wire logic [11:0] first_pos_mv,
   input  wire logic [11:0] first_neg_mv,
   input  wire logic [11:0] second_pos_mv,
   input  wire logic [11:0] second_neg_mv,
   output logic             first_cmp_raw,
   output logic             second_cmp_raw
);
   // No hysteresis modelled; equal inputs give zero
   assign first_cmp_raw  = first_pos_mv > first_neg_mv;
   assign second_cmp_raw = second_pos_mv > second_neg_mv;
endmodule : comparator_pair_analog

// *** verif/comparator_pair_properties.sv ***
// Checker: port-level properties of the comparator pair control block
`timescale 1ns/10ps
module comparator_pair_properties
   import comparator_pair_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst_b,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       first_vector_ack,
   input wire logic       first_event,
   input wire logic       first_irq,
   input wire logic [7:0] first_pos_route,
   input wire logic [7:0] second_neg_pin_route,
   input wire logic       second_neg_divider,
   input wire logic [5:0] divider_factor,
   input wire logic [7:0] pin_out_value,
   input wire logic [7:0] pin_out_enable_b,
   input wire logic       source_enable,
   input wire logic [7:0] source_pin_route,
   input wire logic       window_irq,
   input wire logic [1:0] window_irq_priority
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   unmapped_read_a: assert property (reg_read && reg_addr > ADDR_TRIM |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   status_spare_a: assert property (reg_read && reg_addr == ADDR_STATUS |=> reg_rdata[3] == 1'b0)
      else $error("status bit 3 not zero");
   pos_reserved_a: assert property (reg_write && reg_addr == ADDR_INSEL0 && reg_wdata[5:3] == POS_RESERVED
      |-> ##2 first_pos_route == 8'h00)
      else $error("reserved positive code routed a pin");
   neg_divider_a: assert property (reg_write && reg_addr == ADDR_INSEL1 && reg_wdata[2:0] == NEG_DIVIDER
      |-> ##2 second_neg_divider && second_neg_pin_route == 8'h00)
      else $error("divider code not routed");
   divider_load_a: assert property (reg_write && reg_addr == ADDR_DIVIDER && reg_wdata[5:0] == 6'h2A
      |-> ##2 divider_factor == 6'h2A)
      else $error("divider factor not loaded");
   pin_drive_a: assert property (reg_write && reg_addr == ADDR_PINOUT && reg_wdata[0]
      |-> ##2 !pin_out_enable_b[7])
      else $error("first pin drive not enabled");
   other_pins_a: assert property (pin_out_enable_b[5:0] == 6'h3F && pin_out_value[5:0] == 6'h00)
      else $error("unrelated pin driven");
   source_off_a: assert property (!source_enable |-> source_pin_route == 8'h00)
      else $error("current routed while source off");
   window_quiet_a: assert property (window_irq_priority == 2'h0 && $past(window_irq_priority) == 2'h0
      |-> !window_irq)
      else $error("window request with priority zero");
   ack_clear_a: assert property (first_vector_ack ##1 !first_event |=> !first_irq)
      else $error("first request not cleared by service");
endmodule : comparator_pair_properties
bind comparator_pair_control comparator_pair_properties props_u (.sys_clk, .rst_b, .reg_addr, .reg_wdata,
   .reg_write, .reg_read, .reg_rdata, .first_vector_ack, .first_event, .first_irq, .first_pos_route,
   .second_neg_pin_route, .second_neg_divider, .divider_factor, .pin_out_value, .pin_out_enable_b,
   .source_enable, .source_pin_route, .window_irq, .window_irq_priority);

// *** verif/comparator_pair_control_tb.sv ***
// Testbench: register, routing, edge, flag and window scenarios
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin bad_count++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module comparator_pair_control_tb
   import comparator_pair_pkg::*;
;
   logic sys_clk = 1'b0, rst_b = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
   logic first_vector_ack = 1'b0, second_vector_ack = 1'b0, window_vector_ack = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [11:0] p0 = 12'd200, p1 = 12'd200;
   logic [7:0] reg_rdata, first_pos_route, second_pos_route, first_neg_pin_route, second_neg_pin_route;
   logic [7:0] pin_out_value, pin_out_enable_b, source_pin_route;
   logic [5:0] divider_factor;
   logic [3:0] source_trim_value;
   logic [1:0] first_hysteresis, second_hysteresis, first_irq_priority, second_irq_priority, window_irq_priority;
   logic first_enable, second_enable, first_neg_reference, second_neg_reference, first_neg_divider;
   logic second_neg_divider, source_enable, first_irq, second_irq, window_irq, first_event, second_event;
   logic window_event, first_cmp_raw, second_cmp_raw, seen;
   int bad_count = 0, cmp_count = 0;
   always #4 sys_clk = ~sys_clk;
   comparator_pair_analog analog_u (.first_pos_mv(p0), .first_neg_mv(12'd500), .second_pos_mv(p1),
      .second_neg_mv(12'd500), .first_cmp_raw, .second_cmp_raw);
   comparator_pair_control dut_u (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .first_cmp_raw, .second_cmp_raw, .first_vector_ack, .second_vector_ack, .window_vector_ack, .first_enable,
      .second_enable, .first_hysteresis, .second_hysteresis, .first_pos_route, .second_pos_route,
      .first_neg_pin_route, .second_neg_pin_route, .first_neg_reference, .second_neg_reference,
      .first_neg_divider, .second_neg_divider, .divider_factor, .pin_out_value, .pin_out_enable_b,
      .source_enable, .source_pin_route, .source_trim_value, .first_irq, .second_irq, .window_irq,
      .first_irq_priority, .second_irq_priority, .window_irq_priority, .first_event, .second_event,
      .window_event);
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : wr
   // Read data stands one cycle only, so it is sampled just after that edge
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] ex);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1;
      `CHK("reg_rdata", ex, reg_rdata)
   endtask : rd_chk
   task automatic lvl(input logic [11:0] a, input logic [11:0] b);
      @(posedge sys_clk);
      p0 <= a;
      p1 <= b;
   endtask : lvl
   task automatic ack(input int s);
      @(posedge sys_clk);
      {window_vector_ack, second_vector_ack, first_vector_ack} <= {s == 2, s == 1, s == 0};
      @(posedge sys_clk);
      {window_vector_ack, second_vector_ack, first_vector_ack} <= 3'b000;
   endtask : ack
   // Fixed span collects a pulse anywhere in the filter latency
   task automatic wait_ev(input int s);
      seen = 1'b0;
      repeat (10) begin
         @(posedge sys_clk);
         #1;
         if ((s == 0 ? first_event : s == 1 ? second_event : window_event) === 1'b1) seen = 1'b1;
      end
   endtask : wait_ev
   task automatic t_regs();
      logic [3:0] ad [8] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
      logic [7:0] ex [8] = '{8'hF7, 8'h3F, 8'h03, 8'h2A, 8'h0F, 8'h00, 8'h83, 8'h0F};
      for (int i = 0; i < 16; i++) rd_chk(i[3:0], 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(ad[i], ex[i]);
         rd_chk(ad[i], ex[i]);
      end
      `CHK("divider_factor", 6'h2A, divider_factor)
      `CHK("source_trim_value", 4'hF, source_trim_value)
      `CHK("ctrl_outputs", 7'h7F, {first_enable, first_hysteresis, first_irq_priority, window_irq_priority})
      for (int i = 0; i < 8; i++) wr(ad[i], 8'h00);
   endtask : t_regs
   task automatic t_route();
      logic [7:0] nr [8] = '{8'h01, 8'h02, 8'h08, 8'h20, 8'h80, 8'h00, 8'h00, 8'h00};
      logic [7:0] sc [4] = '{8'h83, 8'h81, 8'h82, 8'h03};
      logic [7:0] sr [4] = '{8'h88, 8'h08, 8'h80, 8'h00};
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_INSEL0, {2'b00, c[2:0], 3'b000});
         wr(ADDR_INSEL1, {5'h00, c[2:0]});
         repeat (3) @(posedge sys_clk);
         #1;
         `CHK("first_pos_route", c == 7 ? 8'h00 : 8'h01 << c, first_pos_route)
         `CHK("second_neg_pin_route", nr[c], second_neg_pin_route)
         `CHK("second_neg_internal", {c == 6, c == 7}, {second_neg_reference, second_neg_divider})
      end
      wr(ADDR_INSEL0, 8'h02);
      wr(ADDR_INSEL1, 8'h04);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_SOURCE, sc[i]);
         repeat (3) @(posedge sys_clk);
         #1;
         `CHK("source_pin_route", sr[i], source_pin_route)
         `CHK("source_enable", sc[i][7], source_enable)
      end
   endtask : t_route
   task automatic t_edges();
      logic [1:0] md [8] = '{2'h3, 2'h3, 2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1};
      logic       lv [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      logic       ee [8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_CTRL0, {md[i], i < 4 ? 2'b01 : 2'b00, 4'h1});
         lvl(lv[i] ? 12'd800 : 12'd200, 12'd200);
         wait_ev(0);
         `CHK("first_event", ee[i], seen)
         `CHK("first_irq", ee[i] && i < 4, first_irq)
         rd_chk(ADDR_STATUS, {3'b000, lv[i], 3'b000, ee[i]});
         if (i == 0) ack(0);
         else wr(ADDR_STATUS, 8'h01);
         rd_chk(ADDR_STATUS, {3'b000, lv[i], 4'h0});
      end
      wr(ADDR_CTRL1, 8'hD1);
      lvl(12'd200, 12'd800);
      wait_ev(1);
      `CHK("second_event", 1'b1, seen)
      `CHK("second_irq", 1'b1, second_irq)
      rd_chk(ADDR_STATUS, 8'h22);
      ack(1);
      rd_chk(ADDR_STATUS, 8'h20);
   endtask : t_edges
   task automatic t_window();
      wr(ADDR_WINDOW, 8'h15);
      rd_chk(ADDR_STATUS, 8'h60);
      lvl(12'd200, 12'd200);
      wait_ev(2);
      rd_chk(ADDR_STATUS, 8'h80);
      lvl(12'd200, 12'd800);
      wait_ev(2);
      `CHK("window_event", 1'b1, seen)
      `CHK("window_irq", 1'b1, window_irq)
      rd_chk(ADDR_STATUS, 8'h66);
      wr(ADDR_STATUS, 8'h00);
      rd_chk(ADDR_STATUS, 8'h66);
      ack(2);
      rd_chk(ADDR_STATUS, 8'h62);
      wr(ADDR_STATUS, 8'h02);
      rd_chk(ADDR_STATUS, 8'h60);
      lvl(12'd800, 12'd800);
      wait_ev(2);
      `CHK("window_event", 1'b0, seen)
      rd_chk(ADDR_STATUS, 8'h30);
      wr(ADDR_WINDOW, 8'h1D);
      lvl(12'd200, 12'd800);
      wait_ev(2);
      lvl(12'd200, 12'd200);
      wait_ev(2);
      `CHK("window_event", 1'b1, seen)
      rd_chk(ADDR_STATUS, 8'h84);
      wr(ADDR_PINOUT, 8'h03);
      lvl(12'd800, 12'd200);
      wait_ev(0);
      `CHK("pin_out_value", 8'h80, pin_out_value)
      `CHK("pin_out_enable_b", 8'h3F, pin_out_enable_b)
   endtask : t_window
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_regs();
      t_route();
      t_edges();
      t_window();
      summarize();
   end
   // Whole sequence needs a few hundred cycles
   initial begin
      #200000;
      bad_count++;
      summarize();
   end
endmodule : comparator_pair_control_tb
